/* File: rtl/ccs_pkg.sv */
package ccs_pkg;

    // Clock and bit timing, in picoseconds
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned BIT_TIME_PS   = 100000;

    // Carrier hold after last bit: 1.5 bit times, least time
    localparam int unsigned CRS_HOLD_PS   = (BIT_TIME_PS * 3) / 2;
    localparam int unsigned CRS_HOLD_CYC  =
        (CRS_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Receive clock tail after carrier drops: 5 bit times, least time
    localparam int unsigned RXC_TAIL_PS   = BIT_TIME_PS * 5;
    localparam int unsigned RXC_TAIL_CYC  =
        (RXC_TAIL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Half period of the recovered clock, longest time
    localparam int unsigned RXC_HALF_PS   = BIT_TIME_PS / 2;
    localparam int unsigned RXC_HALF_CYC  = RXC_HALF_PS / CLK_PERIOD_PS;

    // Least spacing of mid-bit transitions: 3/4 bit, least time
    localparam int unsigned MIN_GAP_PS    = (BIT_TIME_PS * 3) / 4;
    localparam int unsigned MIN_GAP_CYC   =
        (MIN_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Collision signal counts as present within two 10 MHz periods
    localparam int unsigned COL_HOLD_PS   = 200000;
    localparam int unsigned COL_HOLD_CYC  = COL_HOLD_PS / CLK_PERIOD_PS;

    // Window for the heartbeat after the end of transmission
    localparam int unsigned HB_WINDOW_PS  = 3000000;
    localparam int unsigned HB_WINDOW_CYC = HB_WINDOW_PS / CLK_PERIOD_PS;

    // Counter width shared by all timers
    localparam int unsigned CNT_W = 9;

    // Synchroniser bit positions
    localparam int unsigned SY_RX_POS  = 0;
    localparam int unsigned SY_RX_NEG  = 1;
    localparam int unsigned SY_CD_POS  = 2;
    localparam int unsigned SY_CD_NEG  = 3;
    localparam int unsigned SY_CRS_IN  = 4;
    localparam int unsigned SY_COL_IN  = 5;
    localparam int unsigned SY_STRAP   = 6;
    localparam int unsigned SY_LTOG    = 7;
    localparam int unsigned SY_LDATA   = 8;
    localparam int unsigned SY_W       = 9;

    // Signals handed to the media access controller
    typedef struct packed {
        logic carrier;
        logic collision;
        logic rx_data;
        logic rx_strobe;
    } mac_side_t;

    localparam mac_side_t MAC_SIDE_RST = 4'h0;

    typedef enum logic [2:0] {
        TX_IDLE      = 3'h1,
        TX_FRAME     = 3'h2,
        TX_HEARTBEAT = 3'h4
    } tx_state_t;

endpackage

/* File: rtl/carrier_collision_select.sv */
// What this block does
// - Carrier rises on first valid falling transition
// - Carrier held 1.5 bit times past last bit
// - Collision high while 10 MHz signalling seen
// - Internal mode copies carrier, collision onto pins
// - Collision watched from delimiter to frame end
// - Heartbeat sampled after transmission ends
// - Receive clock runs five bits past carrier
// - External data captured on external clock rise
module carrier_collision_select
    import ccs_pkg::*;
#(
    parameter int unsigned HB_WINDOW_CYCLES = HB_WINDOW_CYC
) (
    input  wire logic      clock_i,
    input  wire logic      resetn_i,
    input  wire logic      ce_i,
    input  wire logic      external_codec_select_i,
    input  wire logic      rx_diff_pos_i,
    input  wire logic      rx_diff_neg_i,
    input  wire logic      collision_diff_pos_i,
    input  wire logic      collision_diff_neg_i,
    input  wire logic      carrier_sense_in_i,
    output logic           carrier_sense_out_o,
    output logic           carrier_sense_oe_n_o,
    input  wire logic      collision_in_i,
    output logic           collision_out_o,
    output logic           collision_oe_n_o,
    output logic           recovered_rx_clock_out_o,
    input  wire logic      external_rx_clock_in_i,
    input  wire logic      external_rx_data_in_i,
    input  wire logic      tx_sfd_start_i,
    input  wire logic      tx_active_i,
    output mac_side_t      mac_o,
    output logic           tx_collision_o,
    output logic           heartbeat_seen_o
);

    // Refuse a heartbeat window the counter cannot hold
    if (HB_WINDOW_CYCLES < 2 || HB_WINDOW_CYCLES >= (1 << CNT_W)) begin : g_chk
        $error("HB_WINDOW_CYCLES out of range");
    end

    localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(CRS_HOLD_CYC);
    localparam logic [CNT_W-1:0] TAIL_CNT = CNT_W'(RXC_TAIL_CYC);
    localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(RXC_HALF_CYC);
    localparam logic [CNT_W-1:0] GAP_CNT  = CNT_W'(MIN_GAP_CYC);
    localparam logic [CNT_W-1:0] COL_CNT  = CNT_W'(COL_HOLD_CYC);
    localparam logic [CNT_W-1:0] HB_CNT   = CNT_W'(HB_WINDOW_CYCLES);

    // Link side, clocked by the external receive clock
    logic [1:0] link_rst_q;
    logic       ext_data_q, ext_data_d;
    logic       ext_tog_q,  ext_tog_d;

    always_comb begin
        ext_data_d = external_rx_data_in_i;
        ext_tog_d  = ~ext_tog_q;
    end

    always_ff @(posedge external_rx_clock_in_i) begin
        link_rst_q <= {link_rst_q[0], resetn_i};
        if (!link_rst_q[1]) begin
            ext_data_q <= 1'b0;
            ext_tog_q  <= 1'b0;
        end else begin
            ext_data_q <= ext_data_d;
            ext_tog_q  <= ext_tog_d;
        end
    end

    // Two-stage synchronisers for pins and link-side levels
    logic [SY_W-1:0] sy1_q, sy2_q;
    logic            ltog_q;
    localparam logic [SY_W-1:0] STRAP_MASK =
        {{(SY_W-1){1'b0}}, 1'b1} << SY_STRAP;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            // Strap keeps moving in reset so that it can be caught
            sy1_q  <= {SY_W{external_codec_select_i}} & STRAP_MASK;
            sy2_q  <= sy1_q & STRAP_MASK;
            ltog_q <= 1'b0;
        end else if (ce_i) begin
            sy1_q  <= {ext_data_q, ext_tog_q, external_codec_select_i,
                       collision_in_i, carrier_sense_in_i,
                       collision_diff_neg_i, collision_diff_pos_i,
                       rx_diff_neg_i, rx_diff_pos_i};
            sy2_q  <= sy1_q;
            ltog_q <= sy2_q[SY_LTOG];
        end
    end

    // Strap is caught while reset is held, then frozen
    logic ext_q;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            ext_q <= sy2_q[SY_STRAP];
        end
    end

    // Internal codec: carrier, data and recovered clock
    logic             lvl_prev_q, lvl_prev_d;
    logic             crs_q, crs_d;
    logic             rxd_q, rxd_d;
    logic             rxc_q, rxc_d;
    logic             stb_q, stb_d;
    logic [CNT_W-1:0] hold_q, hold_d;
    logic [CNT_W-1:0] gap_q, gap_d;
    logic [CNT_W-1:0] tail_q, tail_d;
    logic [CNT_W-1:0] half_q, half_d;
    logic             rx_valid, rx_lvl, rx_trans, take;

    always_comb begin
        rx_valid   = sy2_q[SY_RX_POS] ^ sy2_q[SY_RX_NEG];
        rx_lvl     = sy2_q[SY_RX_POS];
        rx_trans   = rx_valid && (rx_lvl != lvl_prev_q);
        // First edge must fall; later ones are mid-bit only
        take       = rx_trans && (crs_q ? (gap_q >= GAP_CNT)
                                        : (lvl_prev_q && !rx_lvl));
        lvl_prev_d = rx_valid ? rx_lvl : lvl_prev_q;
        crs_d      = crs_q;
        rxd_d      = rxd_q;
        stb_d      = 1'b0;
        hold_d     = (hold_q != '0) ? hold_q - 1'b1 : hold_q;
        gap_d      = (gap_q != '1) ? gap_q + 1'b1 : gap_q;
        tail_d     = (tail_q != '0) ? tail_q - 1'b1 : tail_q;
        if (take) begin
            crs_d  = 1'b1;
            hold_d = HOLD_CNT;
            gap_d  = '0;
            rxd_d  = rx_lvl;
            stb_d  = 1'b1;
        end else if (crs_q && hold_q == 1) begin
            crs_d  = 1'b0;
            tail_d = TAIL_CNT;
        end
        // Clock runs during carrier and through the tail
        if (take) begin
            rxc_d  = 1'b0;
            half_d = '0;
        end else if (crs_q || tail_q != '0) begin
            rxc_d  = (half_q == HALF_CNT - 1'b1) ? ~rxc_q : rxc_q;
            half_d = (half_q == HALF_CNT - 1'b1) ? '0 : half_q + 1'b1;
        end else begin
            rxc_d  = 1'b0;
            half_d = '0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            lvl_prev_q <= 1'b0;
            crs_q      <= 1'b0;
            rxd_q      <= 1'b0;
            rxc_q      <= 1'b0;
            stb_q      <= 1'b0;
            hold_q     <= '0;
            gap_q      <= '0;
            tail_q     <= '0;
            half_q     <= '0;
        end else if (ce_i) begin
            lvl_prev_q <= lvl_prev_d;
            crs_q      <= crs_d;
            rxd_q      <= rxd_d;
            rxc_q      <= rxc_d;
            stb_q      <= stb_d;
            hold_q     <= hold_d;
            gap_q      <= gap_d;
            tail_q     <= tail_d;
            half_q     <= half_d;
        end
    end

    // Internal collision detector on the differential pair
    logic             cd_prev_q, cd_prev_d;
    logic             col_q, col_d;
    logic [CNT_W-1:0] colc_q, colc_d;
    logic             cd_lvl, cd_edge;

    always_comb begin
        cd_lvl    = sy2_q[SY_CD_POS] & ~sy2_q[SY_CD_NEG];
        cd_edge   = cd_lvl != cd_prev_q;
        cd_prev_d = cd_lvl;
        colc_d    = cd_edge ? COL_CNT
                  : ((colc_q != '0) ? colc_q - 1'b1 : colc_q);
        col_d     = cd_edge || (colc_q > 1);
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            cd_prev_q <= 1'b0;
            col_q     <= 1'b0;
            colc_q    <= '0;
        end else if (ce_i) begin
            cd_prev_q <= cd_prev_d;
            col_q     <= col_d;
            colc_q    <= colc_d;
        end
    end

    // Source select for the controller and the pin copies
    mac_side_t mac_q, mac_d, src_int, src_ext;
    logic      crs_pin_q, crs_pin_d;
    logic      col_pin_q, col_pin_d;

    always_comb begin
        src_int   = '{carrier: crs_q, collision: col_q,
                      rx_data: rxd_q, rx_strobe: stb_q};
        src_ext   = '{carrier: sy2_q[SY_CRS_IN],
                      collision: sy2_q[SY_COL_IN],
                      rx_data: sy2_q[SY_LDATA],
                      rx_strobe: sy2_q[SY_LTOG] ^ ltog_q};
        mac_d     = ext_q ? src_ext : src_int;
        crs_pin_d = !ext_q && crs_q;
        col_pin_d = !ext_q && col_q;
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            mac_q     <= MAC_SIDE_RST;
            crs_pin_q <= 1'b0;
            col_pin_q <= 1'b0;
        end else if (ce_i) begin
            mac_q     <= mac_d;
            crs_pin_q <= crs_pin_d;
            col_pin_q <= col_pin_d;
        end
    end

    // Transmit collision and heartbeat monitor
    tx_state_t        tx_q, tx_d;
    logic             txcol_q, txcol_d;
    logic             hb_q, hb_d;
    logic [CNT_W-1:0] hbc_q, hbc_d;

    always_comb begin
        tx_d    = tx_q;
        txcol_d = txcol_q;
        hb_d    = hb_q;
        hbc_d   = hbc_q;
        case (tx_q)
            TX_IDLE: begin
                if (tx_sfd_start_i) begin
                    tx_d    = TX_FRAME;
                    txcol_d = mac_d.collision;
                    hb_d    = 1'b0;
                end
            end
            TX_FRAME: begin
                if (mac_d.collision) begin
                    txcol_d = 1'b1;
                end
                if (!tx_active_i) begin
                    tx_d  = TX_HEARTBEAT;
                    hbc_d = HB_CNT;
                end
            end
            TX_HEARTBEAT: begin
                hbc_d = hbc_q - 1'b1;
                if (mac_d.collision) begin
                    hb_d = 1'b1;
                end
                if (tx_sfd_start_i) begin
                    tx_d    = TX_FRAME;
                    txcol_d = mac_d.collision;
                    hb_d    = 1'b0;
                end else if (hbc_q == 1) begin
                    tx_d = TX_IDLE;
                end
            end
            default: tx_d = TX_IDLE;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            tx_q    <= TX_IDLE;
            txcol_q <= 1'b0;
            hb_q    <= 1'b0;
            hbc_q   <= '0;
        end else if (ce_i) begin
            tx_q    <= tx_d;
            txcol_q <= txcol_d;
            hb_q    <= hb_d;
            hbc_q   <= hbc_d;
        end
    end

    // Output pins, all from flip-flops
    assign carrier_sense_out_o      = crs_pin_q;
    assign carrier_sense_oe_n_o     = ext_q;
    assign collision_out_o          = col_pin_q;
    assign collision_oe_n_o         = ext_q;
    assign recovered_rx_clock_out_o = rxc_q;
    assign mac_o                    = mac_q;
    assign tx_collision_o           = txcol_q;
    assign heartbeat_seen_o         = hb_q;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i || !ce_i);

    sequence s_take_then_quiet;
        take ##1 (!take)[*8];
    endsequence

    a_crs_first_edge: assert property (
        (!crs_q && rx_trans && lvl_prev_q) |=> crs_q)
        else $error("carrier missed first falling edge");
    a_crs_hold_time: assert property (
        s_take_then_quiet |-> crs_q)
        else $error("carrier dropped before hold time");
    a_crs_release: assert property (
        (crs_q && hold_q == 1 && !take) |=> !crs_q && tail_q == TAIL_CNT)
        else $error("carrier not released after hold");
    a_col_detect: assert property (
        cd_edge |=> col_q ##1 col_q)
        else $error("collision signalling not flagged");
    a_pin_copy: assert property (
        !ext_q ##1 $changed(crs_q) |=> carrier_sense_out_o == $past(crs_q))
        else $error("carrier pin copy wrong");
    a_src_ext: assert property (
        ext_q |=> mac_o.carrier == $past(sy2_q[SY_CRS_IN]) && !col_pin_q)
        else $error("external source not selected");
    a_src_int: assert property (
        !ext_q |=> mac_o.collision == $past(col_q))
        else $error("internal source not selected");
    a_tx_collision: assert property (
        (tx_q == TX_FRAME && mac_d.collision) |=> tx_collision_o)
        else $error("transmit collision not latched");
    a_heartbeat: assert property (
        (tx_q == TX_HEARTBEAT && mac_d.collision && !tx_sfd_start_i)
        |=> heartbeat_seen_o)
        else $error("heartbeat not latched");
    a_rxc_tail: assert property (
        $fell(crs_q) |-> ##[1:8] $changed(recovered_rx_clock_out_o))
        else $error("receive clock stopped with carrier");
    a_ext_capture: assert property (
        @(posedge external_rx_clock_in_i) disable iff (!link_rst_q[1])
        link_rst_q[1] |=> ext_data_q == $past(external_rx_data_in_i)
        && ext_tog_q != $past(ext_tog_q))
        else $error("external data not captured");

endmodule // carrier_collision_select

/* File: test/codec_partner.sv */
module codec_partner (
    input  wire logic       clock_i,
    output logic [5:0]      pins_o  = 6'h00,
    output logic            lclk_o  = 1'b0,
    output logic            ldata_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pins: rx pos, rx neg, col pos, col neg, carrier, collision

    // Holds the receive pair at one level for some cycles
    task automatic half(input logic lvl, input int cyc);
        @(posedge clock_i);
        pins_o[5:4] <= {lvl, ~lvl};
        repeat (cyc - 1) @(posedge clock_i);
    endtask

    // Manchester bits, first bit first; pair idles equal afterwards
    task automatic send_bits(input logic [7:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            half(~bits[i], 6);
            half(bits[i], 7);
        end
        @(posedge clock_i);
        pins_o[5:4] <= 2'h0;
    endtask

    // Collision pair toggles every 6 cycles, near 10 MHz
    task automatic collide(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clock_i);
            pins_o[3:2] <= {i[0], ~i[0]};
            repeat (5) @(posedge clock_i);
        end
        @(posedge clock_i);
        pins_o[3:2] <= 2'h0;
    endtask

    // External codec carrier and collision levels
    task automatic set_ext(input logic crs, input logic col);
        @(posedge clock_i);
        pins_o[1:0] <= {crs, col};
    endtask

    // Link clock runs only for the frame; data moves on its fall
    task automatic link_frame(input logic [15:0] bits, input int n);
        #1.3;
        for (int i = 0; i < n; i++) begin
            ldata_o <= bits[i];
            #7.5;
            lclk_o <= 1'b1;
            #7.5;
            lclk_o <= 1'b0;
        end
        ldata_o <= ~bits[n-1];
    endtask
endmodule // codec_partner

/* File: test/carrier_collision_select_tb.sv */
module carrier_collision_select_tb
    import ccs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned HB_CYC = 20;

    logic       clock_i, resetn_i, strap, sfd, tx_act, lclk, ldata, ce;
    logic       crs_out, crs_oe_n, col_out, col_oe_n, rxc, tx_col, hb;
    logic       carrier_seen;
    logic [5:0] pins;
    logic       rxd_q[$];
    mac_side_t  mac;
    wire logic  crs_wire;
    wire logic  col_wire;
    int         errors, samples_checked;

    // Shared pin level: device drives while its enable is low
    assign crs_wire = crs_oe_n ? pins[1] : crs_out;
    assign col_wire = col_oe_n ? pins[0] : col_out;

    carrier_collision_select #(.HB_WINDOW_CYCLES(HB_CYC))
    u_carrier_collision_select (
        .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce),
        .external_codec_select_i(strap),
        .rx_diff_pos_i(pins[5]), .rx_diff_neg_i(pins[4]),
        .collision_diff_pos_i(pins[3]), .collision_diff_neg_i(pins[2]),
        .carrier_sense_in_i(crs_wire), .carrier_sense_out_o(crs_out),
        .carrier_sense_oe_n_o(crs_oe_n), .collision_in_i(col_wire),
        .collision_out_o(col_out), .collision_oe_n_o(col_oe_n),
        .recovered_rx_clock_out_o(rxc), .external_rx_clock_in_i(lclk),
        .external_rx_data_in_i(ldata), .tx_sfd_start_i(sfd),
        .tx_active_i(tx_act), .mac_o(mac), .tx_collision_o(tx_col),
        .heartbeat_seen_o(hb)
    );

    codec_partner u_codec_partner (
        .clock_i(clock_i), .pins_o(pins), .lclk_o(lclk), .ldata_o(ldata)
    );

    // Free-running main clock
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    // Compares one value, counts it and reports a mismatch
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%0h expected=%0h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run
    task automatic wrap_up();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Records received bits and checks the pin copies every cycle out of reset
    always @(posedge clock_i) begin
        if (mac.rx_strobe === 1'b1)
            rxd_q.push_back(mac.rx_data);
        if (mac.carrier === 1'b1)
            carrier_seen = 1'b1;
        if (resetn_i === 1'b1) begin
            check(crs_out, crs_oe_n ? 1'b0 : mac.carrier);
            check(col_out, col_oe_n ? 1'b0 : mac.collision);
        end
    end

    // Reset with the strap set; link clock ticks during reset
    task automatic do_reset(input logic external_codec_select);
        @(posedge clock_i);
        resetn_i <= 1'b0;
        strap    <= external_codec_select;
        fork
            u_codec_partner.link_frame(16'h0000, 3);
            repeat (5) @(posedge clock_i);
        join
        @(posedge clock_i);
        resetn_i <= 1'b1;
        @(negedge clock_i);
        check({crs_oe_n, col_oe_n}, {2{external_codec_select}});
    endtask

    // Counts changes of the recovered clock over some cycles
    task automatic count_toggles(input int cyc, output int n);
        logic prev;
        n = 0;
        prev = rxc;
        repeat (cyc) begin
            @(posedge clock_i);
            n += int'(rxc !== prev);
            prev = rxc;
        end
    endtask

    // A lone rising mid-bit edge must not start carrier
    task automatic t_first_rise();
        carrier_seen = 1'b0;
        rxd_q.delete();
        u_codec_partner.send_bits(8'h01, 1);
        repeat (30) @(posedge clock_i);
        check(carrier_seen, 1'b0);
        check(8'(rxd_q.size()), 8'h00);
    endtask

    // Full frame: data, carrier hold and receive clock tail
    task automatic t_frame();
        int n;
        logic [7:0] bits;
        bits = 8'hB6;
        rxd_q.delete();
        u_codec_partner.send_bits(bits, 8);
        repeat (12) @(posedge clock_i);
        check(mac.carrier, 1'b1);
        repeat (10) @(posedge clock_i);
        check(mac.carrier, 1'b0);
        check(8'(rxd_q.size()), 8'h08);
        for (int i = 0; i < 8; i++)
            check(rxd_q[i], bits[i]);
        count_toggles(50, n);
        check(n >= 7, 1'b1);
        repeat (16) @(posedge clock_i);
        count_toggles(30, n);
        check(8'(n), 8'h00);
    endtask

    // Collision signalling on the pair shows while it lasts
    task automatic t_collision();
        u_codec_partner.collide(8);
        repeat (2) @(posedge clock_i);
        check(mac.collision, 1'b1);
        repeat (33) @(posedge clock_i);
        check(mac.collision, 1'b0);
    endtask

    // Clock enable low freezes the block: signalling goes unseen
    task automatic t_freeze();
        ce <= 1'b0;
        u_codec_partner.collide(8);
        repeat (5) @(posedge clock_i);
        check(mac.collision, 1'b0);
        ce <= 1'b1;
        repeat (5) @(posedge clock_i);
        check(mac.collision, 1'b0);
    endtask

    // Starts a frame: delimiter pulse with transmit active
    task automatic pulse_sfd();
        @(posedge clock_i);
        sfd    <= 1'b1;
        tx_act <= 1'b1;
        @(posedge clock_i);
        sfd    <= 1'b0;
    endtask

    // Collision flags in the frame and in the heartbeat window
    task automatic t_tx();
        u_codec_partner.collide(4);
        repeat (35) @(posedge clock_i);
        check({tx_col, hb}, 8'h00);
        pulse_sfd();
        u_codec_partner.collide(4);
        repeat (35) @(posedge clock_i);
        check({tx_col, hb}, 8'h02);
        tx_act <= 1'b0;
        u_codec_partner.collide(4);
        repeat (35) @(posedge clock_i);
        check({tx_col, hb}, 8'h03);
        pulse_sfd();
        repeat (5) @(posedge clock_i);
        check({tx_col, hb}, 8'h00);
        tx_act <= 1'b0;
        repeat (HB_CYC + 10) @(posedge clock_i);
        u_codec_partner.collide(4);
        repeat (35) @(posedge clock_i);
        check({tx_col, hb}, 8'h00);
    endtask

    // External codec: pins become inputs and feed the controller
    task automatic t_external();
        do_reset(1'b1);
        u_codec_partner.set_ext(1'b1, 1'b0);
        repeat (5) @(posedge clock_i);
        check({mac.carrier, mac.collision}, 8'h02);
        u_codec_partner.set_ext(1'b0, 1'b1);
        repeat (5) @(posedge clock_i);
        check({mac.carrier, mac.collision}, 8'h01);
        u_codec_partner.set_ext(1'b0, 1'b0);
        carrier_seen = 1'b0;
        rxd_q.delete();
        u_codec_partner.send_bits(8'hB6, 8);
        repeat (30) @(posedge clock_i);
        check(carrier_seen, 1'b0);
        u_codec_partner.link_frame(16'h00FF, 16);
        repeat (10) @(posedge clock_i);
        check(rxd_q.size() > 0, 1'b1);
        check({rxd_q[0], rxd_q[$]}, 8'h02);
    endtask

    // Main sequence
    initial begin
        resetn_i        = 1'b0;
        ce              = 1'b1;
        strap           = 1'b0;
        sfd             = 1'b0;
        tx_act          = 1'b0;
        carrier_seen    = 1'b0;
        errors          = 0;
        samples_checked = 0;
        do_reset(1'b0);
        t_first_rise();
        t_frame();
        t_collision();
        t_freeze();
        t_tx();
        t_external();
        wrap_up();
    end

    // Watchdog cuts a hang short
    initial begin
        #300000;
        errors++;
        wrap_up();
    end
endmodule // carrier_collision_select_tb
